//--- verilog/ebwic_pkg.sv
// constants, types and register map of the bus wait and idle controller
package ebwic_pkg;
	// register byte addresses on the control bus
	localparam logic [31:0] OFF_IDLE = 32'h0ffff488;
	localparam logic [31:0] OFF_SETUP = 32'h0ffff4a0;
	localparam logic [31:0] OFF_DWLO = 32'h0ffff4a4;
	localparam logic [31:0] OFF_DWHI = 32'h0ffff4a8;
	localparam logic [31:0] OFF_PAGE = 32'h0ffff4ac;
	localparam logic [31:0] OFF_DRAM = 32'h0ffff4b0;
	localparam logic [31:0] OFF_REFR = 32'h0ffff4b4;
	localparam logic [31:0] OFF_STAT = 32'h0ffff4b8;
	// reset values
	localparam logic [15:0] IDLE_RST = 16'hffff;
	localparam logic [15:0] SETUP_RST = 16'hffff;
	localparam logic [15:0] DW_RST = 16'h7777;
	localparam logic [15:0] PAGE_RST = 16'h0007;
	localparam logic [15:0] DRAM_RST = 16'h03ff;
	localparam logic [15:0] REFR_RST = 16'h00ff;
	// field layout
	localparam int unsigned F2 = 2;
	localparam int unsigned F3 = 3;
	localparam int unsigned DW_STRIDE = 4;
	localparam int unsigned DW_PER_REG = 4;
	localparam int unsigned D_RAS = 0;
	localparam int unsigned D_ROW = 2;
	localparam int unsigned D_ACC = 4;
	localparam int unsigned D_CAS = 6;
	localparam int unsigned D_SRP = 8;
	localparam int unsigned R_PRE = 0;
	localparam int unsigned R_ACT = 2;
	localparam int unsigned R_SRL = 5;
	localparam int unsigned S_CS = 6;
	localparam int unsigned S_PIN = 9;
	localparam int unsigned CNT_W = 4;
	localparam logic [3:0] HALF_STRB = 4'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// memory kind of a requested bus cycle
	typedef enum logic [3:0] {
		K_SRAM = 4'h0, K_EROM = 4'h1, K_EIO = 4'h2, K_PROM = 4'h3,
		K_EDO = 4'h4, K_SDRAM = 4'h5, K_CBR = 4'h6, K_SELF = 4'h7,
		K_INT = 4'h8
	} ebwic_kind_t;
	// bus states, one-hot
	typedef enum logic [5:0] {
		S_IDLE = 6'h01, S_SETUP = 6'h02, S_T1 = 6'h04,
		S_TW = 6'h08, S_T2 = 6'h10, S_TI = 6'h20
	} ebwic_state_t;
	// one bus cycle request
	typedef struct packed {
		logic [2:0] cs;
		ebwic_kind_t kind;
		logic write;
		logic on_page;
		logic flyby;
	} ebwic_req_t;
endpackage

//--- verilog/ebwic_sync.sv
// two flip-flop synchroniser for the external wait pin
`timescale 1ns/1ps
module ebwic_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_ff; // first stage, read only by the second
	// idle level is high so a reset does not look like a wait request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= 1'b1;
			sync_out <= 1'b1;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule // ebwic_sync

//--- verilog/ebwic_ctrl.sv
// bus cycle sequencer with programmable waits and idle insertion
`timescale 1ns/1ps
// Function
// - setup 0-3, data 0-7, page 0-7 waits
// - wait pin stretches only data access waits
// - dram wait fields with their minimums
// - idle states inserted after second bus state
// - next cycle only after idles complete
// - idles after static cycles, page rom reads
// - edo read idles, skipped for same space
// - idles after synchronous dram reads
// - two-bit idle count per chip select
// - idle control resets to all maximum
// - idle control only whole 16-bit access
// - no idles for internal areas
// - wait is count or pin, ored
// - wait pin synchronised, sampled after t1/tw
module ebwic_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic req_valid,
	input wire ebwic_pkg::ebwic_req_t req,
	output logic req_ready,
	input wire logic wait_n,
	output ebwic_pkg::ebwic_state_t bus_state,
	output logic strobe_en,
	output logic data_drive_en,
	output logic cycle_done
);
	import ebwic_pkg::*;

	logic [15:0] idle_state_control_ff; // two bits per space
	logic [15:0] address_setup_wait_reg_ff; // two bits per space
	logic [15:0] data_wait_reg_low_ff; // spaces 0-3
	logic [15:0] data_wait_reg_high_ff; // spaces 4-7
	logic [15:0] page_wait_reg_ff; // on-page wait
	logic [15:0] dram_timing_reg_ff; // dram and sdram timing
	logic [15:0] refresh_wait_reg_ff; // refresh timing
	logic have_aw_ff, have_w_ff; // write halves collected
	logic [31:0] awaddr_ff, wdata_ff, araddr_w;
	logic [3:0] wstrb_ff;
	logic wait_s; // synchronised pin, low means wait
	ebwic_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	ebwic_req_t cur_ff; // cycle in progress
	logic [CNT_W-1:0] pre_n, dw_n, idle_n;
	logic pin_ok, hold_tw;
	logic [32:0] wr_dec, rd_dec; // decoded write and read targets

	// wait pin crosses into aclk before anything looks at it
	ebwic_sync u_sync (.aclk(aclk), .aresetn(aresetn), .async_in(wait_n),
		.sync_out(wait_s));

	// minimum of one for fields whose range starts at one
	function automatic logic [CNT_W-1:0] at_least1(input logic [2:0] v);
		return (v == 3'h0) ? CNT_W'(1) : CNT_W'(v);
	endfunction

	// two-bit field of space i in a packed register
	function automatic logic [1:0] fld2(input logic [15:0] r,
		input logic [2:0] i);
		return r[F2*i +: F2];
	endfunction

	// byte address decode to register value
	function automatic logic [32:0] rd_f(input logic [31:0] a,
		input logic [15:0] st);
		case (a)
			OFF_IDLE: rd_f = {1'b1, 16'h0000, idle_state_control_ff};
			OFF_SETUP: rd_f = {1'b1, 16'h0000, address_setup_wait_reg_ff};
			OFF_DWLO: rd_f = {1'b1, 16'h0000, data_wait_reg_low_ff};
			OFF_DWHI: rd_f = {1'b1, 16'h0000, data_wait_reg_high_ff};
			OFF_PAGE: rd_f = {1'b1, 16'h0000, page_wait_reg_ff};
			OFF_DRAM: rd_f = {1'b1, 16'h0000, dram_timing_reg_ff};
			OFF_REFR: rd_f = {1'b1, 16'h0000, refresh_wait_reg_ff};
			OFF_STAT: rd_f = {1'b1, 16'h0000, st};
			default: rd_f = '0; // unmapped
		endcase
	endfunction

	// decode held apart, a select on a call result is not legal
	always_comb begin
		wr_dec = rd_f(awaddr_ff, 16'h0000);
		rd_dec = rd_f(araddr_w, {6'h00, wait_s, cur_ff.cs, state_ff});
	end

	// write channel: both halves in any order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw_ff <= 1'b0;
			have_w_ff <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awaddr_ff <= 32'h00000000;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw_ff <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w_ff <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (have_aw_ff && have_w_ff && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				// idle control refuses anything but a whole halfword
				if (!wr_dec[32] || (awaddr_ff == OFF_IDLE
					&& (wstrb_ff & HALF_STRB) != HALF_STRB)) begin
					s_axi_bresp <= RESP_SLVERR;
				end else begin
					s_axi_bresp <= RESP_OKAY;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				have_aw_ff <= 1'b0;
				have_w_ff <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// register storage; the write lands when the response is raised
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_state_control_ff <= IDLE_RST;
			address_setup_wait_reg_ff <= SETUP_RST;
			data_wait_reg_low_ff <= DW_RST;
			data_wait_reg_high_ff <= DW_RST;
			page_wait_reg_ff <= PAGE_RST;
			dram_timing_reg_ff <= DRAM_RST;
			refresh_wait_reg_ff <= REFR_RST;
		end else if (have_aw_ff && have_w_ff && !s_axi_bvalid) begin
			case (awaddr_ff)
				OFF_IDLE: begin
					// partial lanes leave the whole register untouched
					if ((wstrb_ff & HALF_STRB) == HALF_STRB) begin
						idle_state_control_ff <= wdata_ff[15:0];
					end
				end
				OFF_SETUP: address_setup_wait_reg_ff <= wdata_ff[15:0];
				OFF_DWLO: data_wait_reg_low_ff <= wdata_ff[15:0];
				OFF_DWHI: data_wait_reg_high_ff <= wdata_ff[15:0];
				OFF_PAGE: page_wait_reg_ff <= wdata_ff[15:0];
				OFF_DRAM: dram_timing_reg_ff <= wdata_ff[15:0];
				OFF_REFR: refresh_wait_reg_ff <= wdata_ff[15:0];
				default: begin
				end
			endcase
		end
	end

	// read channel answers one cycle after the address is taken
	assign araddr_w = s_axi_araddr;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_dec[31:0];
			s_axi_rresp <= rd_dec[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// waits ahead of t1: address setup, ras/cas or row precharge
	always_comb begin
		pre_n = '0;
		case (req.kind)
			K_SRAM, K_EROM, K_EIO: pre_n = CNT_W'(fld2(
				address_setup_wait_reg_ff, req.cs));
			K_PROM: pre_n = req.on_page ? '0 : CNT_W'(fld2(
				address_setup_wait_reg_ff, req.cs));
			K_EDO: begin
				// on-page writes need at least one cas precharge
				if (req.on_page) begin
					pre_n = req.write ? at_least1({1'b0,
						dram_timing_reg_ff[D_CAS +: F2]})
						: CNT_W'(dram_timing_reg_ff[D_CAS +: F2]);
				end else begin
					pre_n = at_least1({1'b0, dram_timing_reg_ff[D_RAS +: F2]})
						+ CNT_W'(dram_timing_reg_ff[D_ROW +: F2]);
				end
			end
			K_SDRAM: pre_n = at_least1({1'b0,
				dram_timing_reg_ff[D_SRP +: F2]});
			K_CBR, K_SELF: pre_n = CNT_W'(refresh_wait_reg_ff[R_PRE +: F2]);
			default: pre_n = '0; // internal areas run without waits
		endcase
	end

	// data access waits between t1 and t2
	always_comb begin
		dw_n = '0;
		// read in t1, so it must come from the latched cycle
		case (cur_ff.kind)
			K_SRAM, K_EROM, K_EIO, K_PROM: begin
				if (cur_ff.kind == K_PROM && cur_ff.on_page) begin
					dw_n = CNT_W'(page_wait_reg_ff[F3-1:0]);
				end else if (cur_ff.cs[2]) begin
					dw_n = CNT_W'(data_wait_reg_high_ff[
						DW_STRIDE*cur_ff.cs[1:0] +: F3]);
				end else begin
					dw_n = CNT_W'(data_wait_reg_low_ff[
						DW_STRIDE*cur_ff.cs[1:0] +: F3]);
				end
			end
			K_EDO: dw_n = CNT_W'(dram_timing_reg_ff[D_ACC +: F2]);
			K_CBR: dw_n = at_least1(refresh_wait_reg_ff[R_ACT +: F3]);
			K_SELF: dw_n = at_least1(refresh_wait_reg_ff[R_ACT +: F3])
				+ CNT_W'(refresh_wait_reg_ff[R_SRL +: F3]);
			default: dw_n = '0;
		endcase
	end

	// pin may stretch only static, page rom and flyby edo data waits
	assign pin_ok = (cur_ff.kind inside {K_SRAM, K_EROM, K_EIO, K_PROM})
		|| (cur_ff.flyby && cur_ff.kind == K_EDO);
	assign hold_tw = pin_ok && !wait_s;

	// number of idle states owed after the second bus state
	always_comb begin
		idle_n = CNT_W'(fld2(idle_state_control_ff, cur_ff.cs));
		case (cur_ff.kind)
			K_SRAM, K_EROM, K_EIO: begin
			end
			K_PROM: if (cur_ff.write) idle_n = '0;
			K_EDO: begin
				// back to back reads in one space need no float time
				if (cur_ff.write || (req_valid && req.cs == cur_ff.cs)) begin
					idle_n = '0;
				end
			end
			K_SDRAM: if (cur_ff.write) idle_n = '0;
			default: idle_n = '0;
		endcase
	end

	// next state of the bus sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			S_IDLE: begin
				if (req_valid) begin
					nxt_state = (pre_n != '0) ? S_SETUP : S_T1;
					nxt_cnt = pre_n - CNT_W'(1);
				end
			end
			S_SETUP: begin
				// setup waits never look at the pin
				if (cnt_ff == '0) nxt_state = S_T1;
				else nxt_cnt = cnt_ff - CNT_W'(1);
			end
			S_T1: begin
				nxt_cnt = dw_n;
				nxt_state = (dw_n != '0 || hold_tw) ? S_TW : S_T2;
			end
			S_TW: begin
				nxt_cnt = (cnt_ff == '0) ? '0 : cnt_ff - CNT_W'(1);
				if (nxt_cnt == '0 && !hold_tw) nxt_state = S_T2;
			end
			S_T2: begin
				nxt_cnt = idle_n - CNT_W'(1);
				nxt_state = (idle_n != '0) ? S_TI : S_IDLE;
			end
			S_TI: begin
				// each idle state is one clock long
				if (cnt_ff == '0) nxt_state = S_IDLE;
				else nxt_cnt = cnt_ff - CNT_W'(1);
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	// sequencer registers; the data wait count uses the latched request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= S_IDLE;
			cnt_ff <= '0;
			cur_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			if (state_ff == S_IDLE && req_valid) cur_ff <= req;
		end
	end

	// registered outputs follow the next state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_state <= S_IDLE;
			req_ready <= 1'b1;
			strobe_en <= 1'b0;
			data_drive_en <= 1'b0;
			cycle_done <= 1'b0;
		end else begin
			bus_state <= nxt_state;
			req_ready <= (nxt_state == S_IDLE);
			strobe_en <= nxt_state inside {S_T1, S_TW, S_T2};
			data_drive_en <= (nxt_state inside {S_T1, S_TW, S_T2})
				&& (state_ff == S_IDLE ? req.write : cur_ff.write);
			cycle_done <= (nxt_state == S_IDLE) && (state_ff != S_IDLE);
		end
	end

	// checks
	property p_idle_reset;
		@(posedge aclk) !aresetn |=> idle_state_control_ff == IDLE_RST;
	endproperty
	a_idle_reset: assert property (p_idle_reset)
		else $error("idle control not at reset value");
	property p_no_idle_int;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_T2 && cur_ff.kind == K_INT |=> state_ff == S_IDLE;
	endproperty
	a_no_idle_int: assert property (p_no_idle_int)
		else $error("idle inserted on internal access");
	property p_three_idles;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_T2 && cur_ff.kind == K_SRAM
			&& fld2(idle_state_control_ff, cur_ff.cs) == 2'h3
		|=> state_ff == S_TI [*3] ##1 state_ff == S_IDLE;
	endproperty
	a_three_idles: assert property (p_three_idles)
		else $error("wrong idle count for setting three");
	property p_ready_idle;
		@(posedge aclk) disable iff (!aresetn)
		req_ready |-> bus_state == S_IDLE && state_ff == S_IDLE;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("ready outside idle");
	property p_ti_quiet;
		@(posedge aclk) disable iff (!aresetn)
		bus_state == S_TI |-> !strobe_en && !data_drive_en;
	endproperty
	a_ti_quiet: assert property (p_ti_quiet)
		else $error("strobe or data active in idle state");
	property p_pin_wait;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_T1 && hold_tw |=> state_ff == S_TW;
	endproperty
	a_pin_wait: assert property (p_pin_wait)
		else $error("wait pin ignored after t1");
	property p_setup_no_pin;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_SETUP && cnt_ff == '0 |=> state_ff == S_T1;
	endproperty
	a_setup_no_pin: assert property (p_setup_no_pin)
		else $error("setup wait stretched");
	property p_prom_write;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_T2 && cur_ff.kind == K_PROM && cur_ff.write
		|=> state_ff == S_IDLE;
	endproperty
	a_prom_write: assert property (p_prom_write)
		else $error("idle after page rom write");
	property p_edo_same;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_T2 && cur_ff.kind == K_EDO && req_valid
			&& req.cs == cur_ff.cs |=> state_ff == S_IDLE;
	endproperty
	a_edo_same: assert property (p_edo_same)
		else $error("idle between edo reads of one space");
	property p_sdram_rd;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_T2 && cur_ff.kind == K_SDRAM && !cur_ff.write
			&& fld2(idle_state_control_ff, cur_ff.cs) != 2'h0
		|=> state_ff == S_TI;
	endproperty
	a_sdram_rd: assert property (p_sdram_rd)
		else $error("no idle after sdram read");
	property p_cv_idle;
		@(posedge aclk) disable iff (!aresetn) state_ff == S_TI;
	endproperty
	c_cv_idle: cover property (p_cv_idle);
	property p_cv_pin;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == S_TW && hold_tw ##1 state_ff == S_TW;
	endproperty
	c_cv_pin: cover property (p_cv_pin);
	property p_cv_wr;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
	endproperty
	c_cv_wr: cover property (p_cv_wr);
endmodule // ebwic_ctrl

//--- dv/ebwic_mem_model.sv
// wait pin model of a slow external device on the bus
`timescale 1ns/1ps
module ebwic_mem_model (
	input wire logic aclk,
	input wire logic strobe_en,
	input wire logic [3:0] hold_cycles,
	output logic wait_n
);
	logic [3:0] left_ff; // wait cycles still requested
	logic strb_ff; // strobe level one edge ago
	initial begin
		left_ff = 4'h0;
		strb_ff = 1'b0;
	end
	// count down from the start of each strobe
	always @(posedge aclk) begin
		strb_ff <= strobe_en;
		if (strobe_en && !strb_ff) begin
			left_ff <= hold_cycles;
		end else if (left_ff != 4'h0) begin
			left_ff <= left_ff - 4'h1;
		end
	end
	// pin moves off the clock edge, it is asynchronous; pull-up when idle
	assign #13 wait_n = (left_ff == 4'h0);
endmodule // ebwic_mem_model

//--- dv/ebwic_ctrl_tb.sv
// self-checking bench of the bus wait and idle controller
`timescale 1ns/1ps
module ebwic_ctrl_tb;
	import ebwic_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0, hold = 4'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, req_valid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, req_ready, wait_n, strobe_en, data_drive_en;
	logic cycle_done;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	ebwic_req_t req = '0;
	ebwic_state_t bus_state;
	int err_count = 0, cmp_count = 0;
	bit pre_taken = 0; // next request already taken at a done edge
	logic [15:0] ic, su_r, dlo, dhi; // shadow copies of programmed values
	always #25 aclk = ~aclk;
	ebwic_ctrl ebwic_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .wait_n(wait_n), .bus_state(bus_state),
		.strobe_en(strobe_en), .data_drive_en(data_drive_en),
		.cycle_done(cycle_done));
	ebwic_mem_model ebwic_mem_model_inst (.aclk(aclk),
		.strobe_en(strobe_en), .hold_cycles(hold), .wait_n(wait_n));
	// verdict in one place
	task automatic finish_test();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one comparison, four-state exact
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// register write: address and data offered together
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle count assumed: only the watchdog ends this wait
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
		// one edge apart so the next call never re-drives bready at once
		@(posedge aclk);
	endtask
	// register read and compare of data and response
	task automatic rd(input logic [31:0] a, input logic [31:0] e,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
		@(posedge aclk);
	endtask
	// run one bus cycle and count its setup, wait and idle states
	task automatic cyc(input ebwic_req_t r, input bit keep,
		output int su, output int tw, output int ti);
		int k;
		su = 0;
		tw = 0;
		ti = 0;
		// a request kept from the last call was taken already
		if (!pre_taken) begin
			req <= r;
			req_valid <= 1'b1;
			k = 0;
			do begin
				@(posedge aclk);
				k++;
			end while (req_ready !== 1'b1 && k < 50);
		end
		pre_taken = keep;
		if (!keep) req_valid <= 1'b0;
		for (k = 0; k < 120; k++) begin
			@(posedge aclk);
			if (cycle_done === 1'b1) break;
			if (bus_state === S_SETUP) su++;
			if (bus_state === S_TW) tw++;
			if (bus_state === S_T2) begin
				chk("t2 strb", {1'b1, r.write}, {strobe_en, data_drive_en});
			end
			if (bus_state === S_TI) begin
				ti++;
				chk("ti strobe", 0, {strobe_en, data_drive_en});
				chk("ti ready", 0, req_ready);
			end
		end
		if (k == 120) chk("cycle end", 1, 0);
	endtask
	// expected idle count from kind, direction and space
	function automatic int exp_ti(ebwic_req_t r);
		int n;
		n = ic[int'(r.cs) * 2 +: 2];
		case (r.kind)
			K_SRAM, K_EROM, K_EIO: return n;
			K_PROM, K_EDO, K_SDRAM: return r.write ? 0 : n;
			default: return 0;
		endcase
	endfunction
	// expected data wait of a static cycle
	function automatic int exp_tw(ebwic_req_t r);
		logic [15:0] d;
		d = r.cs[2] ? dhi : dlo;
		return d[int'(r.cs[1:0]) * 4 +: 3];
	endfunction
	// watchdog, far above the planned run
	initial begin
		#(50 * 40000);
		chk("watchdog", 0, 1);
		finish_test();
	end
	// main sequence
	initial begin
		ebwic_req_t r;
		int su, tw, ti, su0, tw0, ti0, i;
		logic [31:0] ra [6];
		logic [15:0] rv [6];
		ra = '{OFF_IDLE, OFF_SETUP, OFF_DWLO, OFF_PAGE, OFF_DRAM, OFF_REFR};
		rv = '{IDLE_RST, SETUP_RST, DW_RST, PAGE_RST, DRAM_RST, REFR_RST};
		void'($urandom(32'hf073bdc2));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (i = 0; i < 6; i++) rd(ra[i], {16'h0, rv[i]}, RESP_OKAY);
		ic = IDLE_RST;
		su_r = SETUP_RST;
		dlo = DW_RST;
		dhi = DW_RST;
		r = '{cs: 3'h5, kind: K_SRAM, write: 1'b0, on_page: 1'b0, flyby: 1'b0};
		cyc(r, 0, su, tw, ti);
		chk("reset ti", 3, ti);
		chk("reset su", 3, su);
		chk("reset tw", 7, tw);
		// partial and unmapped accesses are refused
		wr(OFF_IDLE, 32'h0, 4'h1, RESP_SLVERR);
		rd(OFF_IDLE, 32'h0000ffff, RESP_OKAY);
		wr(32'h0ffff4c0, 32'h1, 4'hf, RESP_SLVERR);
		rd(32'h0ffff4c0, 32'h0, RESP_SLVERR);
		// random waits; space 0 gets no idle, spaces 2 and 7 the most
		su_r = $urandom();
		dlo = $urandom() & 16'h7777;
		dhi = $urandom() & 16'h7777;
		ic = ($urandom() & 16'h3fcc) | 16'hc030;
		wr(OFF_SETUP, {16'h0, su_r}, 4'hf, RESP_OKAY);
		wr(OFF_DWLO, {16'h0, dlo}, 4'hf, RESP_OKAY);
		wr(OFF_DWHI, {16'h0, dhi}, 4'hf, RESP_OKAY);
		wr(OFF_IDLE, {16'ha5a5, ic}, 4'hf, RESP_OKAY);
		rd(OFF_IDLE, {16'h0, ic}, RESP_OKAY);
		// every kind, random space and direction
		for (i = 0; i < 36; i++) begin
			r.cs = (i < 18) ? 3'(i % 8) : 3'($urandom_range(0, 7));
			r.kind = ebwic_kind_t'(i % 9);
			r.write = $urandom_range(0, 1);
			r.on_page = (i < 18) ? 1'(i / 9) : 1'($urandom_range(0, 1));
			r.flyby = $urandom_range(0, 1);
			cyc(r, 0, su, tw, ti);
			chk("idles", exp_ti(r), ti);
			if (r.kind inside {K_SRAM, K_EROM, K_EIO}) begin
				chk("setup", su_r[int'(r.cs) * 2 +: 2], su);
				chk("data wait", exp_tw(r), tw);
			end
			// on-page page rom skips setup and runs on the page wait
			if (r.kind == K_PROM && r.on_page) begin
				chk("page setup", 0, su);
				chk("page wait", PAGE_RST[2:0], tw);
			end
		end
		// back-to-back edo reads to one space skip the idle
		r = '{cs: 3'h2, kind: K_EDO, write: 1'b0, on_page: 1'b0, flyby: 1'b0};
		cyc(r, 1, su, tw, ti);
		chk("edo same", 0, ti);
		cyc(r, 0, su, tw, ti);
		chk("edo last", 3, ti);
		// wait pin stretches static and flyby edo data waits, not sdram or cbr ones; the
		// longest data wait lets the synchronised pin arrive in time
		dhi[14:12] = 3'h7;
		wr(OFF_DWHI, {16'h0, dhi}, 4'hf, RESP_OKAY);
		r.on_page = 1'b0;
		for (i = 0; i < 4; i++) begin
			r.cs = 3'h7;
			r.kind = (i == 0) ? K_SRAM : (i == 1) ? K_SDRAM
				: (i == 2) ? K_CBR : K_EDO;
			r.flyby = (i == 3);
			hold <= 4'h0;
			cyc(r, 0, su0, tw0, ti0);
			hold <= 4'hc;
			cyc(r, 0, su, tw, ti);
			chk("pin su", su0, su);
			chk("pin ti", ti0, ti);
			if (i == 0 || i == 3) chk("pin stretch", 1, tw > tw0 + 4);
			else chk("pin ignored", tw0, tw);
		end
		hold <= 4'h0;
		finish_test();
	end
endmodule // ebwic_ctrl_tb
